//--- shared/vff_pkg.sv
// Constants, modes and state layout of the vertical filter core
package vff_pkg;
  localparam int VFF_TAPS = 8;
  localparam int VFF_LBS = 8;
  localparam int VFF_LB_DEPTH = 4096;
  localparam int VFF_ROWS = 256;
  localparam int VFF_SETS = 16;
  localparam logic [11:0] VFF_CFG_LEN_ADDR = 12'h0200;
  localparam logic [11:0] VFF_CFG_MODE_ADDR = 12'h0201;
  localparam logic [11:0] VFF_CFG_LIM_ADDR = 12'h0202;
  localparam logic [11:0] VFF_CFG_CASC_ADDR = 12'h0203;
  localparam logic [11:0] VFF_COEF_TOP = 12'h00ff;
  localparam logic [11:0] VFF_SEL_BASE = 12'h0300;
  localparam logic [11:0] VFF_RND_BASE = 12'h0310;
  localparam logic [11:0] VFF_LIM_BASE = 12'h0320;
  localparam logic [3:0] VFF_COEF_WORDS = 4'h8;
  localparam logic [3:0] VFF_RND_WORDS = 4'h3;
  localparam logic [3:0] VFF_LIM_WORDS = 4'h6;
  localparam logic [3:0] VFF_ONE_WORD = 4'h1;
  localparam logic [11:0] VFF_LB_EXTRA = 12'h0004;
  localparam logic [11:0] VFF_CASC_TRIM = 12'h0002;
  localparam logic [11:0] VFF_LEN_MAX = 12'h0c00;
  localparam logic [4:0] VFF_SEL_MAX = 5'h10;
  localparam int VFF_MODE_RECIRC = 0;
  localparam int VFF_MODE_PAR = 1;
  localparam int VFF_MODE_FLD = 2;
  localparam int VFF_MODE_FLDLB = 3;
  localparam logic [11:0] VFF_CFG_RST = 12'h0000;
  localparam logic [31:0] VFF_ACC_RST = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    VFF_LD_IDLE = 2'b00,
    VFF_LD_ADDR = 2'b01,
    VFF_LD_DATA = 2'b10
  } vff_ld_e;

  typedef struct packed
  {
    logic [11:0] len;
    logic [11:0] mode;
    logic [11:0] lim;
    logic [11:0] casc;
  } vff_cfg_s;

  typedef struct packed
  {
    vff_ld_e ld_state;
    logic [3:0] ld_cnt;
    logic [11:0] ld_addr;
    logic [95:0] stage;
    logic ld_prev;
    logic [7:0] coef_row;
    logic acc_ctl;
    logic [3:0] set_sel;
    logic [11:0] in_smp;
    logic [11:0] fld_smp;
    logic [11:0] chain;
    logic [11:0] wp;
    logic [31:0] acc;
    vff_cfg_s cfg;
    logic [15:0] q0;
    logic [15:0] q1;
    logic [1:0] q_cnt;
  } vff_state_s;
endpackage

//--- hw/vff_core.sv
// Eight-tap vertical FIR filter core with line buffers and load port
//
// What this block does
// [RL1] Enabled registers update only on rising clock
// [RL2] Main 12-bit sample input registered on edge
// [RL3] Field sample input registered, used in field mode
// [RL4] Load port word captured while load low
// [RL5] Controller holds load high, starts with falling edge
// [RL6] Pause high stalls the loading sequence
// [RL7] Coefficient address picks the bank row
// [RL8] Coefficient address loads only when enable low
// [RL9] Result leaves through registered 16-bit port
// [RL10] Select code n windows bits n+15 to n, codes above 16 act as 16
// [RL11] Cascade output carries delayed samples onward
// [RL12] Length register holds line buffer length
// [RL13] Mode bit chooses delay or recirculate
// [RL14] Load bit chooses normal or parallel fill
// [RL15] Field port and field buffer enable bits
// [RL16] Limit enable bit, reserved bits zero
// [RL17] Chain position bit, reserved bits zero
// [RL18] Accumulate adds and holds output register
// [RL19] Shift enable low advances inputs and buffers unless two results wait and ready is low
// [RL20] Registered selector picks round/select/limit set
// [RL21] Filter output drives only with enable low
// [RL22] Cascade output drives only with enable low
// [RL23] Buffer delay is length setting plus four
// [RL24] Selected round value added before windowing
// [RL25] Limiting clamps to lower and upper bounds
// [RL26] Follower mode trims first buffer by two
// [RL27] Eight products summed into the accumulator
`timescale 1ns/10ps
`default_nettype none
module vff_core
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [11:0] sample_in,
  input wire logic [11:0] field_sample_in,
  input wire logic [11:0] coef_cfg_in,
  input wire logic load_n_in,
  input wire logic pause_in,
  input wire logic [7:0] coef_row_addr_in,
  input wire logic coef_addr_en_n_in,
  input wire logic accumulate_ctl_in,
  input wire logic shift_en_n_in,
  input wire logic [3:0] post_proc_set_sel_in,
  input wire logic filter_out_oe_n_in,
  input wire logic chain_out_oe_n_in,
  input wire logic filter_out_ready_in,
  output logic [15:0] filter_out_out,
  output logic filter_out_oe_out,
  output logic filter_out_valid_out,
  output logic [11:0] chain_out_out,
  output logic chain_out_oe_out,
  output vff_pkg::vff_cfg_s cfg_out
);
  import vff_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [11:0] lb_delay(input logic [11:0] len,
                                           input logic trim);
    logic [11:0] d;
    d = len + VFF_LB_EXTRA;
    if (trim)
    begin
      d = d - VFF_CASC_TRIM;
    end
    return d;
  endfunction

  function automatic logic [3:0] words_for(input logic [11:0] a);
    logic [3:0] w;
    w = VFF_ONE_WORD;
    if (a <= VFF_COEF_TOP)
    begin
      w = VFF_COEF_WORDS;
    end
    else if (a[11:4] == VFF_RND_BASE[11:4])
    begin
      w = VFF_RND_WORDS;
    end
    else if (a[11:4] == VFF_LIM_BASE[11:4])
    begin
      w = VFF_LIM_WORDS;
    end
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Storage

  vff_state_s st;
  vff_state_s next_st;
  logic [95:0] coef_mem [VFF_ROWS];
  logic [31:0] rnd_mem [VFF_SETS];
  logic [63:0] lim_mem [VFF_SETS];
  logic [4:0] sel_mem [VFF_SETS];
  logic [11:0] lb_mem [VFF_LBS][VFF_LB_DEPTH];

  logic [11:0] lb_out [VFF_LBS];
  logic [11:0] lb_in [VFF_LBS];
  logic [11:0] tap [VFF_TAPS];
  logic [95:0] row;
  logic signed [31:0] sum;
  logic signed [23:0] prod;
  logic signed [31:0] rnd;
  logic signed [31:0] lo;
  logic signed [31:0] hi;
  logic [4:0] win;
  logic [31:0] shifted;
  logic [15:0] result;
  logic take;
  logic commit;
  logic coef_we;
  logic rnd_we;
  logic lim_we;
  logic sel_we;
  logic adv;
  logic push;
  logic pop;
  logic shift_go;
  logic [11:0] d_first;
  logic [11:0] d_rest;

  //////////////////////////////////////////////////////////////////////
  // Line buffer taps

  always_comb
  begin
    d_first = lb_delay(st.cfg.len, st.cfg.casc[0]); // [RL26]
    d_rest = lb_delay(st.cfg.len, 1'b0); // [RL23]
    for (int i = 0; i < VFF_LBS; i++)
    begin
      lb_out[i] = lb_mem[i][st.wp - ((i == 0) ? d_first : d_rest)];
    end
    tap[0] = st.in_smp;
    for (int k = 1; k < VFF_TAPS; k++)
    begin
      tap[k] = lb_out[k-1];
    end
    if (st.cfg.mode[VFF_MODE_FLD]) // [RL15]
    begin
      tap[4] = st.cfg.mode[VFF_MODE_FLDLB] ? lb_out[7] : st.fld_smp;
    end
    for (int i = 0; i < VFF_LBS - 1; i++)
    begin
      lb_in[i] = tap[i];
      if (st.cfg.mode[VFF_MODE_PAR]) // [RL14]
      begin
        lb_in[i] = st.in_smp;
      end
      if (st.cfg.mode[VFF_MODE_RECIRC]) // [RL13]
      begin
        lb_in[i] = lb_out[i];
      end
    end
    lb_in[7] = st.cfg.mode[VFF_MODE_RECIRC] ? lb_out[7] : st.fld_smp;
  end

  //////////////////////////////////////////////////////////////////////
  // Multiply, round, limit, window

  always_comb
  begin
    row = coef_mem[st.coef_row]; // [RL7]
    sum = '0;
    for (int k = 0; k < VFF_TAPS; k++)
    begin
      prod = $signed(tap[k]) * $signed(row[12*k +: 12]);
      sum = sum + {{8{prod[23]}}, prod}; // [RL27]
    end
    rnd = $signed(st.acc) + $signed(rnd_mem[st.set_sel]); // [RL24]
    lo = $signed(lim_mem[st.set_sel][31:0]);
    hi = $signed(lim_mem[st.set_sel][63:32]);
    if (st.cfg.lim[0]) // [RL16]
    begin
      if (rnd < lo)
      begin
        rnd = lo; // [RL25]
      end
      else if (rnd > hi)
      begin
        rnd = hi; // [RL25]
      end
    end
    win = sel_mem[st.set_sel]; // [RL20]
    if (win > VFF_SEL_MAX)
    begin
      win = VFF_SEL_MAX;
    end
    shifted = rnd >> win;
    result = shifted[15:0]; // [RL10]
  end

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;
    commit = 1'b0;
    pop = filter_out_valid_out & filter_out_ready_in;
    adv = (st.q_cnt != 2'd2) | pop;
    push = adv & ~st.acc_ctl;
    shift_go = ~shift_en_n_in & adv;
    next_st.ld_prev = load_n_in;
    take = ~load_n_in & ~pause_in; // [RL4] [RL6]
    if (st.ld_state == VFF_LD_IDLE)
    begin
      take = take & st.ld_prev; // [RL5]
    end
    if (load_n_in)
    begin
      next_st.ld_state = VFF_LD_IDLE; // [RL4]
    end
    else if (take)
    begin
      case (st.ld_state)
        VFF_LD_IDLE, VFF_LD_ADDR:
        begin
          next_st.ld_addr = coef_cfg_in;
          next_st.ld_cnt = 4'h0;
          next_st.ld_state = VFF_LD_DATA;
        end
        VFF_LD_DATA:
        begin
          next_st.stage[12*st.ld_cnt +: 12] = coef_cfg_in;
          next_st.ld_cnt = st.ld_cnt + 4'h1;
          if (st.ld_cnt == words_for(st.ld_addr) - 4'h1)
          begin
            commit = 1'b1;
            next_st.ld_state = VFF_LD_ADDR;
          end
        end
        default:
        begin
          next_st.ld_state = VFF_LD_IDLE;
        end
      endcase
    end
    coef_we = commit & (st.ld_addr <= VFF_COEF_TOP);
    sel_we = commit & (st.ld_addr[11:4] == VFF_SEL_BASE[11:4]);
    rnd_we = commit & (st.ld_addr[11:4] == VFF_RND_BASE[11:4]);
    lim_we = commit & (st.ld_addr[11:4] == VFF_LIM_BASE[11:4]);
    if (commit)
    begin
      case (st.ld_addr)
        VFF_CFG_LEN_ADDR:
        begin
          next_st.cfg.len = (coef_cfg_in > VFF_LEN_MAX) ?
                            VFF_LEN_MAX : coef_cfg_in; // [RL12] [RL23]
        end
        VFF_CFG_MODE_ADDR:
        begin
          next_st.cfg.mode = {8'h00, coef_cfg_in[3:0]}; // [RL13] [RL14] [RL15]
        end
        VFF_CFG_LIM_ADDR:
        begin
          next_st.cfg.lim = {11'h000, coef_cfg_in[0]}; // [RL16]
        end
        VFF_CFG_CASC_ADDR:
        begin
          next_st.cfg.casc = {11'h000, coef_cfg_in[0]}; // [RL17]
        end
        default:
        begin
          next_st.cfg = st.cfg;
        end
      endcase
    end
    if (~coef_addr_en_n_in)
    begin
      next_st.coef_row = coef_row_addr_in; // [RL8]
    end
    next_st.acc_ctl = accumulate_ctl_in;
    next_st.set_sel = post_proc_set_sel_in; // [RL20]
    if (shift_go) // [RL19]
    begin
      next_st.in_smp = sample_in; // [RL2]
      if (st.cfg.mode[VFF_MODE_FLD])
      begin
        next_st.fld_smp = field_sample_in; // [RL3]
      end
      next_st.chain = lb_out[6]; // [RL11]
      next_st.wp = st.wp + 12'h001;
    end
    if (adv)
    begin
      next_st.acc = st.acc_ctl ? st.acc + sum : sum; // [RL18]
    end
    if (pop)
    begin
      next_st.q0 = st.q1;
      next_st.q_cnt = st.q_cnt - 2'd1;
    end
    if (push) // [RL18]
    begin
      next_st.q_cnt = next_st.q_cnt + 2'd1;
      if (next_st.q_cnt == 2'd1)
      begin
        next_st.q0 = result;
      end
      else
      begin
        next_st.q1 = result;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_in or negedge rst_b_in) // [RL1]
  begin
    if (!rst_b_in)
    begin
      st <= '0;
      st.ld_state <= VFF_LD_IDLE;
      st.cfg <= {4{VFF_CFG_RST}};
      st.acc <= VFF_ACC_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk_in) // [RL1]
  begin
    if (coef_we)
    begin
      coef_mem[st.ld_addr[7:0]] <= next_st.stage;
    end
    if (sel_we)
    begin
      sel_mem[st.ld_addr[3:0]] <= next_st.stage[4:0];
    end
    if (rnd_we)
    begin
      rnd_mem[st.ld_addr[3:0]] <= next_st.stage[31:0];
    end
    if (lim_we)
    begin
      lim_mem[st.ld_addr[3:0]] <= {next_st.stage[67:36], next_st.stage[31:0]};
    end
    if (shift_go) // [RL19]
    begin
      for (int i = 0; i < VFF_LBS; i++)
      begin
        lb_mem[i][st.wp] <= lb_in[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  assign filter_out_out = st.q0; // [RL9]
  assign filter_out_valid_out = (st.q_cnt != 2'd0);
  assign filter_out_oe_out = ~filter_out_oe_n_in; // [RL21]
  assign chain_out_out = st.chain; // [RL11]
  assign chain_out_oe_out = ~chain_out_oe_n_in; // [RL22]
  assign cfg_out = st.cfg;
endmodule
`default_nettype wire

//--- tb/vff_core_props.sv
// Port checker for the vertical filter core
`timescale 1ns/10ps
`default_nettype none
module vff_core_props
  import vff_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic load_n_in,
  input wire logic shift_en_n_in,
  input wire logic filter_out_oe_n_in,
  input wire logic chain_out_oe_n_in,
  input wire logic filter_out_ready_in,
  input wire logic [15:0] filter_out_out,
  input wire logic filter_out_oe_out,
  input wire logic filter_out_valid_out,
  input wire logic [11:0] chain_out_out,
  input wire logic chain_out_oe_out,
  input wire vff_pkg::vff_cfg_s cfg_out
);
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////
  a_fout_oe_follow:
    assert property (filter_out_oe_out == !filter_out_oe_n_in) else $error("filter oe");
  a_cout_oe_follow:
    assert property (chain_out_oe_out == !chain_out_oe_n_in) else $error("chain oe");
  a_stall_holds:
    assert property (filter_out_valid_out && !filter_out_ready_in |=>
      filter_out_valid_out && $stable(filter_out_out)) else $error("word lost");
  a_pop_needs_ready:
    assert property ($fell(filter_out_valid_out) |-> $past(filter_out_ready_in))
      else $error("drop without ready");
  a_cfg_needs_load:
    assert property (!$stable(cfg_out) |-> !$past(load_n_in) || !$past(load_n_in, 2))
      else $error("cfg changed idle");
  a_resv_zero:
    assert property (cfg_out.lim[11:1] == 11'h000 && cfg_out.casc[11:1] == 11'h000)
      else $error("reserved set");
  a_len_capped:
    assert property (cfg_out.len <= VFF_LEN_MAX) else $error("length too big");
  a_chain_holds:
    assert property (shift_en_n_in |=> $stable(chain_out_out)) else $error("chain moved");
endmodule
bind vff_core vff_core_props i_props (.clk_in, .rst_b_in, .load_n_in, .shift_en_n_in,
  .filter_out_oe_n_in, .chain_out_oe_n_in, .filter_out_ready_in, .filter_out_out,
  .filter_out_oe_out, .filter_out_valid_out, .chain_out_out, .chain_out_oe_out, .cfg_out);
`default_nettype wire

//--- tb/vff_sink.sv
// Result receiver model that can stall the filter output
`timescale 1ns/10ps
`default_nettype none
module vff_sink
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic valid_in,
  input wire logic [15:0] data_in,
  input wire logic slow_in,
  output logic ready_out
);
  logic [1:0] cnt;
  logic [15:0] got [$];
  assign ready_out = !slow_in || cnt == 2'b11;
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cnt <= 2'b00;
    else
    begin
      cnt <= cnt + 2'b01;
      if (valid_in && ready_out)
        got.push_back(data_in);
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking testbench of the vertical filter core
`timescale 1ns/10ps
`default_nettype none
module tb;
  import vff_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [11:0] sample_in = 12'h000;
  logic [11:0] coef_cfg_in = 12'h000;
  logic load_n_in = 1'b1;
  logic pause_in = 1'b0;
  logic [7:0] coef_row_addr_in = 8'h00;
  logic coef_addr_en_n_in = 1'b1;
  logic shift_en_n_in = 1'b1;
  logic [3:0] post_proc_set_sel_in = 4'h0;
  logic filter_out_oe_n_in = 1'b0;
  logic chain_out_oe_n_in = 1'b0;
  logic slow = 1'b0;
  logic seen = 1'b0;
  logic filter_out_ready_in, filter_out_valid_out, filter_out_oe_out, chain_out_oe_out;
  logic [15:0] filter_out_out;
  logic [11:0] chain_out_out;
  vff_cfg_s cfg_out;
  int n_fail = 0;
  int tests_run = 0;
  always #4 clk_in = ~clk_in;
  vff_core i_dut (.clk_in, .rst_b_in, .sample_in, .field_sample_in(12'h000), .coef_cfg_in,
    .load_n_in, .pause_in, .coef_row_addr_in, .coef_addr_en_n_in, .accumulate_ctl_in(1'b0),
    .shift_en_n_in, .post_proc_set_sel_in, .filter_out_oe_n_in, .chain_out_oe_n_in,
    .filter_out_ready_in, .filter_out_out, .filter_out_oe_out, .filter_out_valid_out,
    .chain_out_out, .chain_out_oe_out, .cfg_out);
  vff_sink i_sink (.clk_in, .rst_b_in, .valid_in(filter_out_valid_out),
    .data_in(filter_out_out), .slow_in(slow), .ready_out(filter_out_ready_in));
  ////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task chk(input logic [47:0] g, input logic [47:0] e, input string m);
    tests_run++;
    if (g !== e)
    begin
      $display("wrong value at %0t: %s", $time, m);
      n_fail++;
    end
  endtask
  task wr(input logic [11:0] a, input int n, input logic [95:0] d);
    load_n_in <= 1'b0;
    coef_cfg_in <= a;
    cyc(1);
    for (int i = 0; i < n; i++)
    begin
      coef_cfg_in <= d[12*i+:12];
      cyc(1);
    end
  endtask
  task ld_end;
    load_n_in <= 1'b1;
    cyc(1);
  endtask
  task pulse(input int sp, input logic [15:0] pk);
    int j;
    j = -1;
    i_sink.got.delete();
    shift_en_n_in <= 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      sample_in <= (i == 2) ? 12'h100 : 12'h000;
      cyc(1);
      if (chain_out_out === 12'h100)
        seen = 1'b1;
    end
    shift_en_n_in <= 1'b1;
    cyc(4);
    foreach (i_sink.got[i])
      if (j < 0 && i_sink.got[i] !== 16'h0000)
        j = i;
    if (j < 0)
      j = 0;
    foreach (i_sink.got[i])
      chk(i_sink.got[i], (i == j || i == j + sp) ? pk : 16'h0000, "filter output");
    $display("pulse test done");
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(20000);
    n_fail++;
    summarize;
  end
  initial
  begin
    cyc(4);
    rst_b_in <= 1'b1;
    cyc(1);
    chk({filter_out_valid_out, cfg_out}, 49'h0, "reset state");
    wr(VFF_CFG_LEN_ADDR, 1, 96'hfff);
    wr(VFF_CFG_LIM_ADDR, 1, 96'h1);
    wr(VFF_CFG_MODE_ADDR, 0, 96'h0);
    pause_in <= 1'b1;
    coef_cfg_in <= 12'h00f;
    cyc(1);
    pause_in <= 1'b0;
    coef_cfg_in <= 12'h00a;
    cyc(1);
    ld_end;
    coef_cfg_in <= 12'h203;
    cyc(2);
    chk(cfg_out, {12'hc00, 12'h00a, 12'h001, 12'h000}, "config");
    $display("config test done");
    wr(VFF_CFG_LEN_ADDR, 1, 96'h0);
    wr(VFF_CFG_MODE_ADDR, 1, 96'h0);
    wr(12'h000, 8, 96'h0);
    wr(12'h001, 8, 96'h00_1001);
    wr(VFF_SEL_BASE, 1, 96'h0);
    wr(VFF_SEL_BASE + 12'h001, 1, 96'h1);
    wr(VFF_RND_BASE, 3, 96'h0);
    wr(VFF_RND_BASE + 12'h001, 3, 96'h0);
    wr(VFF_LIM_BASE, 6, 96'h400_0000_0000);
    ld_end;
    coef_addr_en_n_in <= 1'b0;
    coef_row_addr_in <= 8'h01;
    cyc(1);
    coef_addr_en_n_in <= 1'b1;
    coef_row_addr_in <= 8'h00;
    slow <= 1'b1;
    shift_en_n_in <= 1'b0;
    cyc(120);
    slow <= 1'b0;
    shift_en_n_in <= 1'b1;
    cyc(8);
    for (int k = 0; k < 3; k++)
    begin
      wr(VFF_CFG_CASC_ADDR, 1, {95'h0, k == 1});
      wr(VFF_CFG_LIM_ADDR, 1, {95'h0, k == 2});
      ld_end;
      post_proc_set_sel_in <= {3'h0, k == 1};
      pulse(k == 1 ? 2 : 4, k == 0 ? 16'h0100 : k == 1 ? 16'h0080 : 16'h0040);
    end
    chk(seen, 1'b1, "chain output");
    filter_out_oe_n_in <= 1'b1;
    chain_out_oe_n_in <= 1'b1;
    cyc(1);
    chk({filter_out_oe_out, chain_out_oe_out}, 2'b00, "oe off");
    filter_out_oe_n_in <= 1'b0;
    chain_out_oe_n_in <= 1'b0;
    cyc(1);
    chk({filter_out_oe_out, chain_out_oe_out}, 2'b11, "oe on");
    $display("enable test done");
    summarize;
  end
endmodule
`default_nettype wire
